// ### src/cscp_pkg.sv
// Package with the constants and carrier types of the system-control pin block.
package cscp_pkg;
   localparam int ADDR_W = 20;
   localparam int PORT_W = 8;
   localparam logic [7:0] NMI_TYPE = 8'h02;
   localparam logic [ADDR_W-1:0] LOW_BASE_RST = 20'h0_0000;
   localparam logic [ADDR_W-1:0] LOW_TOP_RST = 20'h0_3FFF;
   localparam logic [PORT_W-1:0] PORT_LATCH_RST = 8'hFF;

   // One bus cycle as seen by the pin logic.
   typedef struct packed {
      logic active;
      logic isMem;
      logic isNumerics;
      logic locked;
      logic [ADDR_W-1:0] addr;
   } cscp_cycle_t;

   // Port 1 configuration: latch value, select-function enable, select requests.
   typedef struct packed {
      logic [PORT_W-1:0] latch;
      logic [PORT_W-1:0] selEnable;
      logic [PORT_W-1:0] selHit;
   } cscp_port_t;

   typedef enum logic [2:0] {
      ARB_OWN = 3'b001,
      ARB_WAIT = 3'b010,
      ARB_GRANT = 3'b100
   } cscp_arb_t;
endpackage : cscp_pkg

// ### src/cscp_port_one.sv
// Port 1 output pins: per-pin choice between select function and output latch.
`timescale 1ns/10ps
module cscp_port_one #(
   parameter int PORT_W = 8
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [PORT_W-1:0] latch,
   input wire logic [PORT_W-1:0] selEnable,
   input wire logic [PORT_W-1:0] selHit,
   output logic [PORT_W-1:0] pinOut
);
   genvar i;
   generate
      for (i = 0; i < PORT_W; i++) begin : g_pin
         // Each pin decides on its own, so one pin's mode never touches another.
         wire logic pinNext = selEnable[i] ? ~selHit[i] : latch[i];
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               pinOut[i] <= 1'b1;
            end else begin
               pinOut[i] <= pinNext;
            end
         end
      end
   endgenerate

   // The edge right after reset release still shows the reset level, so it is left out.
   a_pin_follows: assert property (@(posedge clk) disable iff (!arst_n)
      $past(arst_n) |-> pinOut == $past((selEnable & ~selHit) | (~selEnable & latch)))
      else $error("port pin does not follow its selected source");
endmodule : cscp_port_one

// ### src/cscp_sys_ctrl.sv
// Top of the system-control pins: ack, selects, lock, hold grant, NMI latch, float strap.
`timescale 1ns/10ps
// How it works
// - ackLineB low acknowledges a request on extIrqLineB; they form a handshake pair.
// - Lower select goes low for memory cycles inside the programmed lower range.
// - Lock output goes low throughout a bus cycle that must stay indivisible.
// - No hold grant is given while the lock output is active.
// - Numerics select goes low for coprocessor accesses, high otherwise.
// - A high NMI input requests service of interrupt type 2, ignoring the mask.
// - NMI assertion is latched and stays pending until it is serviced.
// - Strap low during reset floats the ack, both select, lock, bus and port 1 pins; other outputs keep driving.
// - In pin-float mode the oscillator drive keeps driving.
// - Each port 1 pin is its own general-purpose output or select output.
// - Bus is handed over only at an instruction boundary not under lock.
// - While hold grant is high the data bus, lower select and lock output are floated.
module cscp_sys_ctrl #(
   parameter int ADDR_W = cscp_pkg::ADDR_W,
   parameter int PORT_W = cscp_pkg::PORT_W
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire cscp_pkg::cscp_cycle_t cycle,
   input wire logic [ADDR_W-1:0] lowBase,
   input wire logic [ADDR_W-1:0] lowTop,
   input wire cscp_pkg::cscp_port_t portCfg,
   input wire logic instrBoundary,
   input wire logic holdReq,
   input wire logic nmiIn,
   input wire logic nmiServiced,
   input wire logic extIrqLineB,
   input wire logic irqAckReq,
   input wire logic floatStrapN,
   input wire logic oscDrive,
   output logic ackLineBOut,
   output logic ackLineBOe,
   output logic irqPendingB,
   output logic lowSelN,
   output logic lowSelOe,
   output logic lockN,
   output logic lockOe,
   output logic numSelN,
   output logic numSelOe,
   output logic holdGrant,
   output logic busOe,
   output logic nmiPending,
   output logic [7:0] nmiType,
   output logic [PORT_W-1:0] portOneOut,
   output logic portOneOe,
   output logic oscOut,
   output logic floatMode
);
   // Strap capture: reset holds the flop at zero; the first clock edge while reset is
   // still low cannot exist with an async reset, so a sampling flag tracks reset.
   logic inReset_reg;
   logic floatMode_reg;
   logic nmiPending_reg;
   logic lockN_reg;
   cscp_pkg::cscp_arb_t arb_reg;
   cscp_pkg::cscp_arb_t arb_next;

   wire logic lowHit = cycle.active && cycle.isMem && cycle.addr >= lowBase && cycle.addr <= lowTop;
   wire logic numHit = cycle.active && cycle.isNumerics;
   wire logic lockNow = cycle.active && cycle.locked;
   // The lock flop joins the release test, so the edge right after a locked cycle still refuses a grant.
   wire logic canRelease = instrBoundary && !lockNow && lockN_reg;
   wire logic pinsOe = !floatMode_reg;

   always_comb begin
      arb_next = arb_reg;
      case (arb_reg)
         cscp_pkg::ARB_OWN: begin
            if (holdReq) begin
               arb_next = canRelease ? cscp_pkg::ARB_GRANT : cscp_pkg::ARB_WAIT;
            end
         end
         cscp_pkg::ARB_WAIT: begin
            if (!holdReq) begin
               arb_next = cscp_pkg::ARB_OWN;
            end else if (canRelease) begin
               arb_next = cscp_pkg::ARB_GRANT;
            end
         end
         cscp_pkg::ARB_GRANT: begin
            if (!holdReq) begin
               arb_next = cscp_pkg::ARB_OWN;
            end
         end
         default: arb_next = cscp_pkg::ARB_OWN;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         inReset_reg <= 1'b1;
      end else begin
         inReset_reg <= 1'b0;
      end
   end

   // The first edge after release still sees the strap as it stood in reset.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         floatMode_reg <= 1'b0;
      end else if (inReset_reg) begin
         floatMode_reg <= !floatStrapN;
      end
   end

   // A high NMI level wins over a service in the same cycle, so a fresh request is never lost.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         nmiPending_reg <= 1'b0;
      end else begin
         nmiPending_reg <= nmiIn || (nmiPending_reg && !nmiServiced);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         arb_reg <= cscp_pkg::ARB_OWN;
         lockN_reg <= 1'b1;
      end else begin
         arb_reg <= arb_next;
         lockN_reg <= !lockNow;
      end
   end

   // Enables float in test mode; bus, lower select and lock enables also float while the bus is granted away; the oscillator pin has no enable.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ackLineBOut <= 1'b1;
         ackLineBOe <= 1'b1;
         irqPendingB <= 1'b0;
         lowSelN <= 1'b1;
         lowSelOe <= 1'b1;
         lockOe <= 1'b1;
         numSelN <= 1'b1;
         numSelOe <= 1'b1;
         holdGrant <= 1'b0;
         busOe <= 1'b1;
         nmiType <= 8'h00;
         portOneOe <= 1'b1;
         oscOut <= 1'b0;
      end else begin
         irqPendingB <= extIrqLineB;
         ackLineBOut <= !(irqAckReq && extIrqLineB);
         ackLineBOe <= floatMode_reg;
         lowSelN <= !lowHit;
         lowSelOe <= floatMode_reg || arb_next == cscp_pkg::ARB_GRANT;
         lockOe <= floatMode_reg || arb_next == cscp_pkg::ARB_GRANT;
         numSelN <= !numHit;
         numSelOe <= floatMode_reg;
         holdGrant <= arb_next == cscp_pkg::ARB_GRANT;
         busOe <= floatMode_reg || arb_next == cscp_pkg::ARB_GRANT;
         nmiType <= cscp_pkg::NMI_TYPE;
         portOneOe <= floatMode_reg;
         oscOut <= oscDrive;
      end
   end

   assign lockN = lockN_reg;
   assign nmiPending = nmiPending_reg;
   assign floatMode = floatMode_reg;

   cscp_port_one #(.PORT_W(PORT_W)) cscp_port_one_i (
      .clk(clk),
      .arst_n(arst_n),
      .latch(portCfg.latch),
      .selEnable(portCfg.selEnable),
      .selHit(portCfg.selHit),
      .pinOut(portOneOut)
   );

   // Assertions look at registered outputs, so most of them judge one edge after the cause.
   a_grant_lock: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(holdGrant) |-> $past(lockN_reg))
      else $error("hold granted while lock active");
   a_lock_blocks: assert property (@(posedge clk) disable iff (!arst_n)
      !lockN && !holdGrant |=> !holdGrant)
      else $error("hold grant rose while lock output active");
   a_lock_follow: assert property (@(posedge clk) disable iff (!arst_n)
      lockNow |=> !lockN)
      else $error("lock output not asserted for locked cycle");
   a_low_select: assert property (@(posedge clk) disable iff (!arst_n)
      lowHit |=> !lowSelN)
      else $error("lower select missing for range hit");
   a_low_idle: assert property (@(posedge clk) disable iff (!arst_n)
      !lowHit |=> lowSelN)
      else $error("lower select active outside range");
   a_num_select: assert property (@(posedge clk) disable iff (!arst_n)
      numHit |=> !numSelN && numSelOe == $past(floatMode))
      else $error("numerics select wrong");
   a_nmi_hold: assert property (@(posedge clk) disable iff (!arst_n)
      nmiPending && !nmiServiced && !nmiIn |=> nmiPending [*1])
      else $error("pending NMI lost");
   a_nmi_catch: assert property (@(posedge clk) disable iff (!arst_n)
      nmiIn |=> nmiPending && nmiType == cscp_pkg::NMI_TYPE)
      else $error("NMI not latched");
   a_float_stable: assert property (@(posedge clk) disable iff (!arst_n)
      !inReset_reg |=> $stable(floatMode_reg))
      else $error("float mode changed outside reset");
   a_float_pins: assert property (@(posedge clk) disable iff (!arst_n)
      floatMode ##1 floatMode |-> busOe && portOneOe && ackLineBOe && lowSelOe && lockOe && numSelOe)
      else $error("pin driven in float mode");
   a_osc_drives: assert property (@(posedge clk) disable iff (!arst_n)
      1'b1 |=> oscOut == $past(oscDrive))
      else $error("oscillator drive not passed");
   a_grant_float: assert property (@(posedge clk) disable iff (!arst_n)
      holdGrant |-> busOe)
      else $error("bus driven during hold grant");
   a_ack_pair: assert property (@(posedge clk) disable iff (!arst_n)
      !ackLineBOut |-> $past(extIrqLineB))
      else $error("ack without request");

   c_grant: cover property (@(posedge clk) disable iff (!arst_n) $rose(holdGrant));
   c_wait_lock: cover property (@(posedge clk) disable iff (!arst_n) holdReq && !lockN ##1 holdReq && !holdGrant);
   c_nmi: cover property (@(posedge clk) disable iff (!arst_n) $fell(nmiIn) ##1 nmiPending);
   c_float: cover property (@(posedge clk) disable iff (!arst_n) floatMode);
   c_set_clear: cover property (@(posedge clk) disable iff (!arst_n) nmiIn && nmiServiced);
endmodule : cscp_sys_ctrl

// ### testbench/cscp_far_model.sv
// Far-side model: an external bus master and a cascaded interrupt expander.
`timescale 1ns/10ps
module cscp_far_model (
   input wire logic clk,
   input wire logic wantBus,
   input wire logic wantIrq,
   input wire logic ackLineBOut,
   output logic holdReq,
   output logic extIrqLineB
);
   assign holdReq = wantBus;
   // The expander withdraws its request once it sees the acknowledge low.
   always @(posedge clk) begin
      extIrqLineB <= wantIrq && ackLineBOut;
   end
endmodule : cscp_far_model

// ### testbench/tb_top.sv
// Self-checking testbench of the system-control pin block.
`timescale 1ns/10ps
module tb_top;
   logic clk = 1'b0, arst_n = 1'b0, instrBoundary = 1'b0, nmiIn = 1'b0, nmiServiced = 1'b0;
   logic irqAckReq = 1'b0, floatStrapN = 1'b1, oscDrive = 1'b0, wantBus = 1'b0, wantIrq = 1'b0;
   logic holdReq, extIrqLineB, ackLineBOut, ackLineBOe, irqPendingB, lowSelN, lowSelOe, lockN, lockOe;
   logic numSelN, numSelOe, holdGrant, busOe, nmiPending, portOneOe, oscOut, floatMode;
   logic [7:0] nmiType, portOneOut;
   logic [19:0] lowBase = 20'h0_1000, lowTop = 20'h0_1FFF;
   cscp_pkg::cscp_cycle_t cyc = '0;
   cscp_pkg::cscp_port_t portCfg = '0;
   int errorCnt = 0, testsRun = 0;
   always #20 clk = ~clk;

   cscp_sys_ctrl cscp_sys_ctrl_i (.clk(clk), .arst_n(arst_n), .cycle(cyc), .lowBase(lowBase), .lowTop(lowTop),
      .portCfg(portCfg), .instrBoundary(instrBoundary), .holdReq(holdReq), .nmiIn(nmiIn),
      .nmiServiced(nmiServiced), .extIrqLineB(extIrqLineB), .irqAckReq(irqAckReq), .floatStrapN(floatStrapN),
      .oscDrive(oscDrive), .ackLineBOut(ackLineBOut), .ackLineBOe(ackLineBOe), .irqPendingB(irqPendingB),
      .lowSelN(lowSelN), .lowSelOe(lowSelOe), .lockN(lockN), .lockOe(lockOe), .numSelN(numSelN),
      .numSelOe(numSelOe), .holdGrant(holdGrant), .busOe(busOe), .nmiPending(nmiPending), .nmiType(nmiType),
      .portOneOut(portOneOut), .portOneOe(portOneOe), .oscOut(oscOut), .floatMode(floatMode));
   cscp_far_model cscp_far_model_i (.clk(clk), .wantBus(wantBus), .wantIrq(wantIrq), .ackLineBOut(ackLineBOut),
      .holdReq(holdReq), .extIrqLineB(extIrqLineB));

   task automatic chk(input string nm, input logic [19:0] got, input logic [19:0] exp);
      testsRun++;
      if (got !== exp) begin
         errorCnt++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic endSim;
      $display("checks %0d mismatches %0d", testsRun, errorCnt);
      if (errorCnt == 0 && testsRun > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : endSim

   // The strap must already be valid at the first edge after release.
   task automatic doReset(input logic strapN);
      @(negedge clk);
      arst_n = 1'b0;
      floatStrapN = strapN;
      repeat (2) @(negedge clk);
      chk("rstPort", portOneOut, 8'hFF);
      chk("rstGrant", {holdGrant, nmiPending, lowSelN}, 3'b001);
      arst_n = 1'b1;
      @(negedge clk);
   endtask : doReset

   task automatic tSelects;
      // Each entry: isMem, isNumerics, locked, addr, expected lower select, expected numerics select.
      logic [24:0] tab [5] = '{{3'b100, 20'h0_1000, 2'b01}, {3'b100, 20'h0_1FFF, 2'b01},
         {3'b100, 20'h0_2000, 2'b11}, {3'b010, 20'h0_1800, 2'b10}, {3'b101, 20'h0_0FFF, 2'b11}};
      foreach (tab[k]) begin
         cyc = '{1'b1, tab[k][24], tab[k][23], tab[k][22], tab[k][21:2]};
         @(negedge clk);
         chk("lowSel", lowSelN, tab[k][1]);
         chk("numSel", numSelN, tab[k][0]);
         chk("lock", lockN, !tab[k][22]);
      end
      cyc = '0;
      $display("test selects done");
   endtask : tSelects

   task automatic tHold;
      @(negedge clk);
      cyc = '{1'b1, 1'b1, 1'b0, 1'b1, 20'h0_0100};
      wantBus = 1'b1;
      instrBoundary = 1'b1;
      repeat (3) begin
         @(negedge clk);
         chk("grantLocked", holdGrant, 1'b0);
      end
      cyc.locked = 1'b0;
      instrBoundary = 1'b0;
      repeat (3) begin
         @(negedge clk);
         chk("grantMidInstr", holdGrant, 1'b0);
      end
      instrBoundary = 1'b1;
      @(negedge clk);
      chk("grantGiven", {holdGrant, busOe, lockOe}, 3'b111);
      wantBus = 1'b0;
      instrBoundary = 1'b0;
      @(negedge clk);
      chk("grantBack", {holdGrant, busOe}, 2'b00);
      cyc = '0;
      $display("test hold done");
   endtask : tHold

   task automatic tNmi;
      chk("nmiIdle", nmiPending, 1'b0);
      nmiIn = 1'b1;
      @(negedge clk);
      nmiIn = 1'b0;
      repeat (3) begin
         @(negedge clk);
         chk("nmiHeld", {nmiPending, nmiType}, 9'h102);
      end
      nmiServiced = 1'b1;
      @(negedge clk);
      nmiServiced = 1'b0;
      @(negedge clk);
      chk("nmiCleared", nmiPending, 1'b0);
      nmiIn = 1'b1;
      nmiServiced = 1'b1;
      @(negedge clk);
      chk("nmiSetWins", nmiPending, 1'b1);
      nmiIn = 1'b0;
      @(negedge clk);
      nmiServiced = 1'b0;
      chk("nmiServed", nmiPending, 1'b0);
      $display("test nmi done");
   endtask : tNmi

   task automatic tAck;
      wantIrq = 1'b1;
      repeat (3) @(negedge clk);
      chk("ackIdle", {ackLineBOut, ackLineBOe}, 2'b10);
      chk("irqSeen", irqPendingB, 1'b1);
      irqAckReq = 1'b1;
      @(negedge clk);
      chk("ackLow", ackLineBOut, 1'b0);
      repeat (2) @(negedge clk);
      chk("ackHigh", ackLineBOut, 1'b1);
      wantIrq = 1'b0;
      irqAckReq = 1'b0;
      $display("test ack done");
   endtask : tAck

   task automatic tPort;
      portCfg = '{8'hA5, 8'h0F, 8'h05};
      @(negedge clk);
      chk("portLowSel", {portOneOut, portOneOe}, 9'h154);
      portCfg = '{8'hA5, 8'hF0, 8'h30};
      @(negedge clk);
      chk("portHighSel", portOneOut, 8'hC5);
      $display("test port done");
   endtask : tPort

   task automatic tFloat;
      doReset(1'b0);
      floatStrapN = 1'b1;
      for (int v = 1; v >= 0; v--) begin
         oscDrive = v[0];
         @(negedge clk);
         chk("oscDrives", oscOut, v[0]);
      end
      chk("allFloat", {floatMode, busOe, lockOe, lowSelOe, numSelOe, ackLineBOe, portOneOe}, 7'h7F);
      doReset(1'b1);
      chk("floatOff", {floatMode, busOe, portOneOe}, 3'b000);
      $display("test float done");
   endtask : tFloat

   initial begin
      doReset(1'b1);
      tSelects();
      tHold();
      tNmi();
      tAck();
      tPort();
      tFloat();
      endSim();
   end

   // The tests need well under two hundred cycles.
   initial begin
      repeat (2000) @(posedge clk);
      errorCnt++;
      endSim();
   end
endmodule : tb_top
